/* File: hdl/kbc_command_set.sv */
// command interpreter of the keyboard and pointing-device controller
// Operation
// - commands 21-3F return RAM byte
// - commands 61-7F store next data byte
// - password query answers FA or F1
// - password load until zero or eight bytes
// - arming needs password; then commands ignored
// - pointer disable/enable sets/clears mode bit5
// - pointer line test reports codes 00-04
// - keyboard line test reports codes 00-04
// - self-test returns 55 with interrupt; system flag untouched
// - legacy dump: sixteen RAM, input, output
// - keyboard disable bit4; host send re-enables
// - legacy bit5 skips parity checking
// - read input port overwrites output buffer
// - poll commands borrow status bits 4-7
// - read output port returns port byte
// - output port write keeps protected bits
// - keyboard inject loads buffer as keyboard
// - pointer inject loads buffer as pointer
// - send-to-pointer forwards next data byte
// - unexpected data byte goes to keyboard
// - test inputs read, bit0 keyboard clock
// - interrupts follow buffer loads and enables
// - output-full set on load, cleared read
// - writes set input-full and command/data
`timescale 1ns/10ps
`include "kbc_defs.svh"
`default_nettype none
module kbc_command_set #(
	parameter int RAM_WORDS = 32,
	parameter int PW_BYTES = 8,
	parameter int DUMP_BYTES = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic host_cs_n,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic host_a2,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	input wire logic legacy_mode,
	input wire logic [7:0] input_port,
	input wire logic test_input_b,
	input wire logic kb_rx_valid,
	input wire logic [7:0] kb_rx_data,
	input wire logic kb_rx_parity_err,
	input wire logic kb_clock_line,
	output logic kb_clock_out,
	output logic kb_clock_oe_n,
	input wire logic kb_data_line,
	output logic kb_data_out,
	output logic kb_data_oe_n,
	input wire logic pointer_clock_line,
	output logic pointer_clock_out,
	output logic pointer_clock_oe_n,
	input wire logic pointer_data_line,
	output logic pointer_data_out,
	output logic pointer_data_oe_n,
	output logic kb_tx_valid,
	output logic [7:0] kb_tx_data,
	output logic pointer_tx_valid,
	output logic [7:0] pointer_tx_data,
	output logic [7:0] output_port,
	output logic kb_interrupt,
	output logic pointer_interrupt
);
	localparam logic [15:0] SETTLE = 16'(`LT_SETTLE_CYC);
	localparam logic [4:0] DUMP_IN = 5'(DUMP_BYTES);
	localparam logic [3:0] PW_FULL = 4'(PW_BYTES);

	logic [7:0] ram [RAM_WORDS];
	logic [7:0] pw [PW_BYTES];
	kbc_pkg::state_e state, next_state;
	kbc_pkg::pend_e pend, next_pend;
	logic [4:0] pend_addr, next_pend_addr, dump_idx, next_dump_idx;
	logic [7:0] mode, next_mode, ob, next_ob, ibuf, next_ibuf, next_rdata, next_outp;
	logic out_buffer_full, next_obf, ods, next_ods, perr, next_perr, in_buffer_full, next_ibf, cd, next_cd;
	logic poll_en, next_poll_en, armed, next_armed, lt_ptr, next_lt_ptr;
	logic lt_clk_low, next_lt_clk_low, lt_dat_low, next_lt_dat_low;
	logic [3:0] poll_val, next_poll_val, pw_len, next_pw_len, pw_cmp, next_pw_cmp;
	logic [15:0] lt_cnt, next_lt_cnt;
	logic next_kb_tx_valid, next_ptr_tx_valid, next_kb_irq, next_ptr_irq;
	logic ram_we, pw_we, ld, ld_ptr, accept, clk_in, dat_in, kb_hold, ptr_hold;
	logic [4:0] ram_addr;
	logic [7:0] ram_wdata, ld_val, status;

	// mode byte doubles as RAM byte 0
	function automatic logic [7:0] rd_ram(input logic [4:0] a);
		rd_ram = (a == 5'h00) ? mode : ram[a];
	endfunction : rd_ram

	// protected output port bits survive a write
	function automatic logic [7:0] merge_port(input logic [7:0] old, input logic [7:0] nw, input logic [7:0] keep);
		merge_port = (old & keep) | (nw & ~keep);
	endfunction : merge_port

	// status byte; polling borrows the top nibble until the next command write
	always_comb begin
		status = {perr, 1'b0, (legacy_mode ? 1'b0 : ods), input_port[7], cd, mode[`MODE_SYS], in_buffer_full, out_buffer_full};
		if (poll_en) begin
			status[7:4] = poll_val;
		end
	end

	// next-state logic for the whole interpreter
	always_comb begin
		next_state = state;
		next_pend = pend;
		next_pend_addr = pend_addr;
		next_dump_idx = dump_idx;
		next_mode = mode;
		next_ob = ob;
		next_obf = out_buffer_full;
		next_ods = ods;
		next_perr = perr;
		next_ibf = in_buffer_full;
		next_ibuf = ibuf;
		next_cd = cd;
		next_poll_en = poll_en;
		next_poll_val = poll_val;
		next_armed = armed;
		next_pw_len = pw_len;
		next_pw_cmp = pw_cmp;
		next_lt_ptr = lt_ptr;
		next_lt_cnt = lt_cnt;
		next_lt_clk_low = lt_clk_low;
		next_lt_dat_low = lt_dat_low;
		next_outp = output_port;
		next_rdata = host_rdata;
		next_kb_tx_valid = 1'b0;
		next_ptr_tx_valid = 1'b0;
		ram_we = 1'b0;
		ram_addr = pend_addr;
		ram_wdata = ibuf;
		pw_we = 1'b0;
		ld = 1'b0;
		ld_val = ob;
		ld_ptr = 1'b0;
		accept = in_buffer_full && (state == kbc_pkg::ST_IDLE);
		clk_in = lt_ptr ? pointer_clock_line : kb_clock_line;
		dat_in = lt_ptr ? pointer_data_line : kb_data_line;
		if (!host_cs_n && host_rd) begin
			next_rdata = host_a2 ? status : ob;
			if (!host_a2) begin
				next_obf = 1'b0;
			end
		end
		// keyboard bytes feed the password check while armed, else the buffer
		if (kb_rx_valid && !mode[`MODE_KB_OFF]) begin
			if (armed) begin
				if (kb_rx_data != pw[pw_cmp[2:0]]) begin
					next_pw_cmp = 4'h0;
				end else if (pw_cmp + 4'h1 == pw_len) begin
					next_armed = 1'b0;
					next_pw_cmp = 4'h0;
				end else begin
					next_pw_cmp = pw_cmp + 4'h1;
				end
			end else if (!out_buffer_full) begin
				ld = 1'b1;
				ld_val = kb_rx_data;
				next_perr = kb_rx_parity_err && !(legacy_mode && mode[`MODE_BIT5]);
				if (next_perr) begin
					ld_val = `RES_PARITY_FILL;
				end
			end
		end
		// one byte from the input buffer is consumed per idle cycle
		if (accept) begin
			next_ibf = 1'b0;
			if (cd) begin
				next_pend = kbc_pkg::P_NONE;
				if (!armed) begin
					if (ibuf >= 8'h21 && ibuf <= 8'h3f) begin
						ld = 1'b1;
						ld_val = rd_ram(ibuf[4:0]);
					end else if (ibuf >= 8'h61 && ibuf <= 8'h7f) begin
						next_pend = kbc_pkg::P_RAM;
						next_pend_addr = ibuf[4:0];
					end else begin
						case (ibuf)
							`CMD_READ_MODE: begin
								ld = 1'b1;
								ld_val = mode;
							end
							`CMD_WRITE_MODE: next_pend = kbc_pkg::P_MODE;
							`CMD_SELF_TEST: begin
								ld = 1'b1;
								ld_val = `RES_SELF_OK;
							end
							`CMD_KB_TEST: begin
								next_lt_ptr = 1'b0;
								next_lt_cnt = SETTLE;
								next_state = kbc_pkg::ST_REL;
							end
							`CMD_KB_OFF: next_mode[`MODE_KB_OFF] = 1'b1;
							`CMD_KB_ON: next_mode[`MODE_KB_OFF] = 1'b0;
							`CMD_READ_IN: begin
								ld = 1'b1;
								ld_val = input_port;
							end
							`CMD_READ_OUT: begin
								ld = 1'b1;
								ld_val = output_port;
							end
							`CMD_WRITE_OUT: next_pend = kbc_pkg::P_OUT;
							`CMD_READ_TEST: begin
								ld = 1'b1;
								ld_val = {6'h00, test_input_b, kb_clock_line};
							end
							default: begin
								if (legacy_mode) begin
									if (ibuf == `CMD_DUMP) begin
										next_dump_idx = 5'h00;
										next_state = kbc_pkg::ST_DUMP;
									end
								end else begin
									case (ibuf)
										`CMD_PW_TEST: begin
											ld = 1'b1;
											ld_val = (pw_len != 4'h0) ? `RES_PW_YES : `RES_PW_NO;
										end
										`CMD_PW_LOAD: begin
											next_pw_len = 4'h0;
											next_pend = kbc_pkg::P_PW;
										end
										`CMD_PW_ARM: next_armed = (pw_len != 4'h0);
										`CMD_PTR_OFF: next_mode[`MODE_BIT5] = 1'b1;
										`CMD_PTR_ON: next_mode[`MODE_BIT5] = 1'b0;
										`CMD_PTR_TEST: begin
											next_lt_ptr = 1'b1;
											next_lt_cnt = SETTLE;
											next_state = kbc_pkg::ST_REL;
										end
										`CMD_POLL_LO: begin
											next_poll_en = 1'b1;
											next_poll_val = input_port[3:0];
										end
										`CMD_POLL_HI: begin
											next_poll_en = 1'b1;
											next_poll_val = input_port[7:4];
										end
										`CMD_KB_INJECT: next_pend = kbc_pkg::P_KINJ;
										`CMD_PTR_INJECT: next_pend = kbc_pkg::P_PINJ;
										`CMD_PTR_SEND: next_pend = kbc_pkg::P_PSEND;
										default: next_pend = kbc_pkg::P_NONE;
									endcase
								end
							end
						endcase
					end
				end
			end else begin
				next_pend = kbc_pkg::P_NONE;
				case (pend)
					kbc_pkg::P_MODE: next_mode = ibuf;
					kbc_pkg::P_RAM: begin
						if (pend_addr == 5'h00) begin
							next_mode = ibuf;
						end else begin
							ram_we = 1'b1;
						end
					end
					kbc_pkg::P_PW: begin
						pw_we = 1'b1;
						next_pw_len = pw_len + 4'h1;
						if (ibuf != 8'h00 && pw_len + 4'h1 < PW_FULL) begin
							next_pend = kbc_pkg::P_PW;
						end
					end
					kbc_pkg::P_OUT: next_outp = merge_port(output_port, ibuf,
						legacy_mode ? `OUT_KEEP_LEGACY : `OUT_KEEP_EXT);
					kbc_pkg::P_KINJ: begin
						ld = 1'b1;
						ld_val = ibuf;
					end
					kbc_pkg::P_PINJ: begin
						ld = 1'b1;
						ld_val = ibuf;
						ld_ptr = 1'b1;
					end
					kbc_pkg::P_PSEND: next_ptr_tx_valid = 1'b1;
					default: begin
						next_kb_tx_valid = 1'b1;
						next_mode[`MODE_KB_OFF] = 1'b0;
					end
				endcase
			end
		end
		// line test walk: release, then pull clock low, then pull data low
		if (lt_cnt != 16'h0000) begin
			next_lt_cnt = lt_cnt - 16'h0001;
		end
		case (state)
			kbc_pkg::ST_IDLE: next_state = next_state;
			kbc_pkg::ST_REL: begin
				if (lt_cnt == 16'h0000) begin
					ld = !clk_in || !dat_in;
					ld_val = !clk_in ? `RES_CLK_LOW : `RES_DAT_LOW;
					next_lt_clk_low = clk_in && dat_in;
					next_lt_cnt = SETTLE;
					next_state = (clk_in && dat_in) ? kbc_pkg::ST_CLK : kbc_pkg::ST_IDLE;
				end
			end
			kbc_pkg::ST_CLK: begin
				if (lt_cnt == 16'h0000) begin
					ld = clk_in;
					ld_val = `RES_CLK_HIGH;
					next_lt_clk_low = 1'b0;
					next_lt_dat_low = !clk_in;
					next_lt_cnt = SETTLE;
					next_state = clk_in ? kbc_pkg::ST_IDLE : kbc_pkg::ST_DAT;
				end
			end
			kbc_pkg::ST_DAT: begin
				if (lt_cnt == 16'h0000) begin
					ld = 1'b1;
					ld_val = dat_in ? `RES_DAT_HIGH : `RES_NO_FAULT;
					next_lt_dat_low = 1'b0;
					next_state = kbc_pkg::ST_IDLE;
				end
			end
			kbc_pkg::ST_DUMP: begin
				if (!out_buffer_full) begin
					ld = 1'b1;
					ld_val = (dump_idx < DUMP_IN) ? rd_ram(dump_idx) :
						(dump_idx == DUMP_IN) ? input_port : output_port;
					next_dump_idx = dump_idx + 5'h01;
					if (dump_idx == DUMP_IN + 5'h01) begin
						next_state = kbc_pkg::ST_IDLE;
					end
				end
			end
			default: next_state = kbc_pkg::ST_IDLE;
		endcase
		if (ld) begin
			next_ob = ld_val;
			next_obf = 1'b1;
			next_ods = ld_ptr;
		end
		if (!host_cs_n && host_wr) begin
			next_ibf = 1'b1;
			next_ibuf = host_wdata;
			next_cd = host_a2;
			if (host_a2) begin
				next_poll_en = 1'b0;
			end
		end
		next_kb_irq = next_obf && !next_ods && mode[`MODE_KB_INT];
		next_ptr_irq = next_obf && next_ods && mode[`MODE_PTR_INT] && !legacy_mode;
		next_outp[4] = next_kb_irq;
		next_outp[5] = next_ptr_irq;
	end

	// idle holds: disabled devices see their clock driven high
	assign kb_hold = mode[`MODE_KB_OFF] && (state == kbc_pkg::ST_IDLE);
	assign ptr_hold = mode[`MODE_BIT5] && !legacy_mode && (state == kbc_pkg::ST_IDLE);

	// storage arrays take no reset beyond the mode byte; contents are software's
	always_ff @(posedge clk) begin
		if (ram_we) begin
			ram[ram_addr] <= ram_wdata;
		end
		if (pw_we) begin
			pw[pw_len[2:0]] <= ibuf;
		end
	end

	// register every next value
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= kbc_pkg::ST_IDLE;
			pend <= kbc_pkg::P_NONE;
			pend_addr <= 5'h00;
			dump_idx <= 5'h00;
			mode <= `MODE_RESET;
			ob <= 8'h00;
			out_buffer_full <= 1'b0;
			ods <= 1'b0;
			perr <= 1'b0;
			in_buffer_full <= 1'b0;
			ibuf <= 8'h00;
			cd <= 1'b0;
			poll_en <= 1'b0;
			poll_val <= 4'h0;
			armed <= 1'b0;
			pw_len <= 4'h0;
			pw_cmp <= 4'h0;
			lt_ptr <= 1'b0;
			lt_cnt <= 16'h0000;
			lt_clk_low <= 1'b0;
			lt_dat_low <= 1'b0;
			output_port <= `OUT_PORT_RESET;
			host_rdata <= 8'h00;
			kb_tx_valid <= 1'b0;
			kb_tx_data <= 8'h00;
			pointer_tx_valid <= 1'b0;
			pointer_tx_data <= 8'h00;
			kb_interrupt <= 1'b0;
			pointer_interrupt <= 1'b0;
			kb_clock_out <= 1'b0;
			kb_clock_oe_n <= 1'b1;
			kb_data_out <= 1'b0;
			kb_data_oe_n <= 1'b1;
			pointer_clock_out <= 1'b0;
			pointer_clock_oe_n <= 1'b1;
			pointer_data_out <= 1'b0;
			pointer_data_oe_n <= 1'b1;
		end else begin
			state <= next_state;
			pend <= next_pend;
			pend_addr <= next_pend_addr;
			dump_idx <= next_dump_idx;
			mode <= next_mode;
			ob <= next_ob;
			out_buffer_full <= next_obf;
			ods <= next_ods;
			perr <= next_perr;
			in_buffer_full <= next_ibf;
			ibuf <= next_ibuf;
			cd <= next_cd;
			poll_en <= next_poll_en;
			poll_val <= next_poll_val;
			armed <= next_armed;
			pw_len <= next_pw_len;
			pw_cmp <= next_pw_cmp;
			lt_ptr <= next_lt_ptr;
			lt_cnt <= next_lt_cnt;
			lt_clk_low <= next_lt_clk_low;
			lt_dat_low <= next_lt_dat_low;
			output_port <= next_outp;
			host_rdata <= next_rdata;
			kb_tx_valid <= next_kb_tx_valid;
			pointer_tx_valid <= next_ptr_tx_valid;
			if (next_kb_tx_valid) begin
				kb_tx_data <= ibuf;
			end
			if (next_ptr_tx_valid) begin
				pointer_tx_data <= ibuf;
			end
			kb_interrupt <= next_kb_irq;
			pointer_interrupt <= next_ptr_irq;
			kb_clock_out <= kb_hold;
			kb_clock_oe_n <= !(kb_hold || (lt_clk_low && !lt_ptr));
			kb_data_out <= 1'b0;
			kb_data_oe_n <= !(lt_dat_low && !lt_ptr);
			pointer_clock_out <= ptr_hold;
			pointer_clock_oe_n <= !(ptr_hold || (lt_clk_low && lt_ptr));
			pointer_data_out <= 1'b0;
			pointer_data_oe_n <= !(lt_dat_low && lt_ptr);
		end
	end
endmodule : kbc_command_set
`default_nettype wire

/* File: hdl/kbc_defs.svh */
// constants for the keyboard controller command interpreter
`ifndef KBC_DEFS_SVH
`define KBC_DEFS_SVH
`define CMD_READ_MODE 8'h20
`define CMD_WRITE_MODE 8'h60
`define CMD_PW_TEST 8'ha4
`define CMD_PW_LOAD 8'ha5
`define CMD_PW_ARM 8'ha6
`define CMD_PTR_OFF 8'ha7
`define CMD_PTR_ON 8'ha8
`define CMD_PTR_TEST 8'ha9
`define CMD_SELF_TEST 8'haa
`define CMD_KB_TEST 8'hab
`define CMD_DUMP 8'hac
`define CMD_KB_OFF 8'had
`define CMD_KB_ON 8'hae
`define CMD_READ_IN 8'hc0
`define CMD_POLL_LO 8'hc1
`define CMD_POLL_HI 8'hc2
`define CMD_READ_OUT 8'hd0
`define CMD_WRITE_OUT 8'hd1
`define CMD_KB_INJECT 8'hd2
`define CMD_PTR_INJECT 8'hd3
`define CMD_PTR_SEND 8'hd4
`define CMD_READ_TEST 8'he0
`define RES_PW_YES 8'hfa
`define RES_PW_NO 8'hf1
`define RES_SELF_OK 8'h55
`define RES_NO_FAULT 8'h00
`define RES_CLK_LOW 8'h01
`define RES_CLK_HIGH 8'h02
`define RES_DAT_LOW 8'h03
`define RES_DAT_HIGH 8'h04
`define RES_PARITY_FILL 8'hff
`define MODE_KB_INT 0
`define MODE_PTR_INT 1
`define MODE_SYS 2
`define MODE_KB_OFF 4
`define MODE_BIT5 5
`define MODE_RESET 8'h10
`define OUT_PORT_RESET 8'h00
`define OUT_KEEP_LEGACY 8'hc0
`define OUT_KEEP_EXT 8'hcc
`define LT_SETTLE_NS 10000
`define CLK_PERIOD_NS 50
`define LT_SETTLE_CYC ((`LT_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: hdl/kbc_pkg.sv */
// types shared by the keyboard controller command interpreter
`default_nettype none
package kbc_pkg;
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_REL = 5'b00010,
		ST_CLK = 5'b00100,
		ST_DAT = 5'b01000,
		ST_DUMP = 5'b10000
	} state_e;
	typedef enum logic [7:0] {
		P_NONE = 8'b00000001,
		P_MODE = 8'b00000010,
		P_RAM = 8'b00000100,
		P_PW = 8'b00001000,
		P_OUT = 8'b00010000,
		P_KINJ = 8'b00100000,
		P_PINJ = 8'b01000000,
		P_PSEND = 8'b10000000
	} pend_e;
endpackage : kbc_pkg
`default_nettype wire

/* File: verification/kbc_command_set_props.sv */
// assertion checker for the keyboard controller command interpreter
`timescale 1ns/10ps
`default_nettype none
module kbc_command_set_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic host_cs_n,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic host_a2,
	input wire logic [7:0] host_wdata,
	input wire logic [7:0] host_rdata,
	input wire logic legacy_mode,
	input wire logic kb_tx_valid,
	input wire logic [7:0] kb_tx_data,
	input wire logic pointer_tx_valid,
	input wire logic [7:0] pointer_tx_data,
	input wire logic [7:0] output_port,
	input wire logic kb_interrupt,
	input wire logic pointer_interrupt
);
	logic rd_taken;
	logic data_wr;
	logic [7:0] last_data;
	logic [7:0] next_last_data;
	// host strobes as the design takes them
	assign rd_taken = !host_cs_n && host_rd;
	assign data_wr = !host_cs_n && host_wr && !host_a2;
	// last data byte: anything forwarded must be what the host wrote
	always_comb begin
		next_last_data = data_wr ? host_wdata : last_data;
	end
	always_ff @(posedge clk) begin
		last_data <= rst ? 8'h00 : next_last_data;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	chk_irq_one_source: assert property (!(kb_interrupt && pointer_interrupt))
		else $error("both interrupts high together");
	chk_ptr_irq_legacy: assert property (legacy_mode && $past(legacy_mode) |-> !pointer_interrupt)
		else $error("pointer interrupt in legacy mode");
	chk_port_kb_irq: assert property (
		output_port[4] == kb_interrupt || output_port[4] == $past(kb_interrupt))
		else $error("output port bit 4 does not follow keyboard interrupt");
	chk_port_ptr_irq: assert property (
		output_port[5] == pointer_interrupt || output_port[5] == $past(pointer_interrupt))
		else $error("output port bit 5 does not follow pointer interrupt");
	chk_kb_tx_pulse: assert property (kb_tx_valid |=> !kb_tx_valid)
		else $error("keyboard send strobe longer than one cycle");
	chk_kb_tx_byte: assert property (kb_tx_valid |-> kb_tx_data == last_data)
		else $error("keyboard byte differs from host data byte");
	chk_ptr_tx_byte: assert property (
		pointer_tx_valid |-> pointer_tx_data == last_data ##1 !pointer_tx_valid)
		else $error("pointer byte wrong or strobe too long");
	chk_rdata_hold: assert property (!$past(rd_taken) |-> $stable(host_rdata))
		else $error("read data changed without a read");
	chk_irq_read_drop: assert property (rd_taken && !host_a2 && kb_interrupt |-> ##[1:3] !kb_interrupt)
		else $error("keyboard interrupt stays after data read");
	chk_reset_quiet: assert property (
		$past(rst) |-> output_port == 8'h00 && !kb_tx_valid && !kb_interrupt)
		else $error("outputs not quiet after reset");
endmodule : kbc_command_set_props
bind kbc_command_set kbc_command_set_props props_u (.clk, .rst, .host_cs_n, .host_rd, .host_wr, .host_a2,
	.host_wdata, .host_rdata, .legacy_mode, .kb_tx_valid, .kb_tx_data, .pointer_tx_valid, .pointer_tx_data,
	.output_port, .kb_interrupt, .pointer_interrupt);
`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the keyboard controller command interpreter
`timescale 1ns/10ps
`default_nettype none
module tb;
	typedef struct packed {
		logic legacy;
		logic [7:0] code;
		logic has_par;
		logic [7:0] par;
		logic has_res;
		logic [7:0] res;
	} row_s;
	row_s rows [17];
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic host_cs_n = 1'b1;
	logic host_rd = 1'b0;
	logic host_wr = 1'b0;
	logic host_a2 = 1'b0;
	logic [7:0] host_wdata = 8'h00;
	logic legacy_mode = 1'b0;
	logic [7:0] input_port = 8'h9a;
	logic test_input_b = 1'b1;
	logic kb_rx_valid = 1'b0;
	logic [7:0] kb_rx_data = 8'h00;
	logic kb_rx_parity_err = 1'b0;
	logic [1:0] fc = 2'b00;
	logic [1:0] fd = 2'b00;
	logic kb_clock_out, kb_clock_oe_n, kb_data_out, kb_data_oe_n, kb_tx_valid, kb_interrupt;
	logic pointer_clock_out, pointer_clock_oe_n, pointer_data_out, pointer_data_oe_n;
	logic pointer_tx_valid, pointer_interrupt;
	logic [7:0] host_rdata, kb_tx_data, pointer_tx_data, output_port;
	logic [7:0] kb_sent = 8'h00;
	logic [7:0] ptr_sent = 8'h00;
	int num_errors = 0;
	int tests_run = 0;
	// lines are pulled up when released; fc/fd force a stuck line (bit1 on, bit0 level)
	wire kb_clock_line = fc[1] ? fc[0] : (kb_clock_oe_n | kb_clock_out);
	wire kb_data_line = fd[1] ? fd[0] : (kb_data_oe_n | kb_data_out);
	wire pointer_clock_line = fc[1] ? fc[0] : (pointer_clock_oe_n | pointer_clock_out);
	wire pointer_data_line = fd[1] ? fd[0] : (pointer_data_oe_n | pointer_data_out);
	kbc_command_set dut_u (.clk, .rst, .host_cs_n, .host_rd, .host_wr, .host_a2, .host_wdata, .host_rdata,
		.legacy_mode, .input_port, .test_input_b, .kb_rx_valid, .kb_rx_data, .kb_rx_parity_err,
		.kb_clock_line, .kb_clock_out, .kb_clock_oe_n, .kb_data_line, .kb_data_out, .kb_data_oe_n,
		.pointer_clock_line, .pointer_clock_out, .pointer_clock_oe_n, .pointer_data_line,
		.pointer_data_out, .pointer_data_oe_n, .kb_tx_valid, .kb_tx_data, .pointer_tx_valid,
		.pointer_tx_data, .output_port, .kb_interrupt, .pointer_interrupt);
	// 20 MHz clock
	always #25 clk = ~clk;
	// catch the one-cycle send strobes, which are easy to miss by polling
	always @(posedge clk) begin
		if (kb_tx_valid === 1'b1)
			kb_sent <= kb_tx_data;
		if (pointer_tx_valid === 1'b1)
			ptr_sent <= pointer_tx_data;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop;
		$display("comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop
	task automatic reset_dut;
		rst = 1'b1;
		repeat (20) @(posedge clk);
		#2;
		rst = 1'b0;
	endtask : reset_dut
	// one host access: strobe for one cycle, then a spare edge so read data has settled
	task automatic bus(input logic a2, input logic w, input logic [7:0] d);
		@(posedge clk);
		#2;
		host_cs_n = 1'b0;
		host_a2 = a2;
		host_wr = w;
		host_rd = !w;
		host_wdata = d;
		@(posedge clk);
		#2;
		host_cs_n = 1'b1;
		host_wr = 1'b0;
		host_rd = 1'b0;
		@(posedge clk);
		#2;
	endtask : bus
	task automatic rd(input logic a2, output logic [7:0] v);
		bus(a2, 1'b0, 8'h00);
		v = host_rdata;
	endtask : rd
	// write, then poll status until the byte has been taken (line tests hold it long)
	task automatic wr(input logic a2, input logic [7:0] d);
		logic [7:0] s;
		bus(a2, 1'b1, d);
		s = 8'h02;
		for (int i = 0; i < 400 && s[1] !== 1'b0; i++)
			rd(1'b1, s);
	endtask : wr
	// wait for output-full, then read the data port and compare
	task automatic expect_res(input logic [7:0] exp);
		logic [7:0] s;
		logic [7:0] v;
		s = 8'h00;
		for (int i = 0; i < 400 && s[0] !== 1'b1; i++)
			rd(1'b1, s);
		rd(1'b0, v);
		check(v, exp);
	endtask : expect_res
	// one received keyboard byte, valid for a single cycle
	task automatic kb_byte(input logic [7:0] d, input logic pe);
		@(posedge clk);
		#2;
		kb_rx_valid = 1'b1;
		kb_rx_data = d;
		kb_rx_parity_err = pe;
		@(posedge clk);
		#2;
		kb_rx_valid = 1'b0;
	endtask : kb_byte
	// hang guard: the whole run needs well under a third of this
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		report_and_stop();
	end
	initial begin
		logic [7:0] s;
		rows = '{{1'b0, 8'h20, 1'b0, 8'h00, 1'b1, 8'h10}, {1'b0, 8'h60, 1'b1, 8'h00, 1'b0, 8'h00},
			{1'b0, 8'h20, 1'b0, 8'h00, 1'b1, 8'h00}, {1'b0, 8'h65, 1'b1, 8'ha5, 1'b0, 8'h00},
			{1'b0, 8'h25, 1'b0, 8'h00, 1'b1, 8'ha5}, {1'b0, 8'h7f, 1'b1, 8'h3c, 1'b0, 8'h00},
			{1'b0, 8'h3f, 1'b0, 8'h00, 1'b1, 8'h3c}, {1'b0, 8'ha4, 1'b0, 8'h00, 1'b1, 8'hf1},
			{1'b0, 8'haa, 1'b0, 8'h00, 1'b1, 8'h55}, {1'b0, 8'hc0, 1'b0, 8'h00, 1'b1, 8'h9a},
			{1'b0, 8'he0, 1'b0, 8'h00, 1'b1, 8'h03}, {1'b0, 8'hd1, 1'b1, 8'hff, 1'b0, 8'h00},
			{1'b0, 8'hd0, 1'b0, 8'h00, 1'b1, 8'h03}, {1'b0, 8'hd2, 1'b1, 8'h5e, 1'b1, 8'h5e},
			{1'b0, 8'hd3, 1'b1, 8'h6b, 1'b1, 8'h6b}, {1'b1, 8'hd1, 1'b1, 8'hff, 1'b0, 8'h00},
			{1'b1, 8'hd0, 1'b0, 8'h00, 1'b1, 8'h0f}};
		reset_dut();
		foreach (rows[i]) begin
			legacy_mode = rows[i].legacy;
			wr(1'b1, rows[i].code);
			if (rows[i].has_par)
				wr(1'b0, rows[i].par);
			if (rows[i].has_res)
				expect_res(rows[i].res);
		end
		$display("command table done");
		legacy_mode = 1'b0;
		wr(1'b1, 8'hc1);
		rd(1'b1, s);
		check(s & 8'hf8, 8'ha8);
		wr(1'b1, 8'hc2);
		rd(1'b1, s);
		check(s & 8'hf8, 8'h98);
		wr(1'b1, 8'had);
		rd(1'b1, s);
		check(s & 8'hf8, 8'h18);
		check({6'h0, kb_clock_oe_n, kb_clock_out}, 8'h01);
		wr(1'b0, 8'hed);
		rd(1'b1, s);
		check(s & 8'hf8, 8'h10);
		check(kb_sent, 8'hed);
		wr(1'b1, 8'h20);
		expect_res(8'h00);
		$display("poll and keyboard disable done");
		wr(1'b1, 8'ha7);
		check({6'h0, pointer_clock_oe_n, pointer_clock_out}, 8'h01);
		wr(1'b1, 8'h20);
		expect_res(8'h20);
		wr(1'b1, 8'ha8);
		check({7'h0, pointer_clock_oe_n}, 8'h01);
		wr(1'b1, 8'hd4);
		wr(1'b0, 8'hf4);
		check(ptr_sent, 8'hf4);
		$display("pointer control done");
		wr(1'b1, 8'h60);
		wr(1'b0, 8'h03);
		wr(1'b1, 8'hb0);
		wr(1'b1, 8'hac);
		rd(1'b1, s);
		check({5'h0, s[0], kb_interrupt, pointer_interrupt}, 8'h00);
		wr(1'b1, 8'haa);
		check({6'h0, kb_interrupt, pointer_interrupt}, 8'h02);
		wr(1'b1, 8'hc0);
		expect_res(8'h9a);
		wr(1'b1, 8'hd3);
		wr(1'b0, 8'h77);
		check({6'h0, kb_interrupt, pointer_interrupt}, 8'h01);
		expect_res(8'h77);
		rd(1'b1, s);
		check({5'h0, s[0], kb_interrupt, pointer_interrupt}, 8'h00);
		legacy_mode = 1'b1;
		wr(1'b1, 8'hd3);
		wr(1'b0, 8'h5a);
		check(kb_sent, 8'h5a);
		$display("interrupt cases done");
		for (int t = 0; t < 5; t++) begin
			fc = (t == 1) ? 2'b10 : (t == 2) ? 2'b11 : 2'b00;
			fd = (t == 3) ? 2'b10 : (t == 4) ? 2'b11 : 2'b00;
			legacy_mode = 1'b1;
			wr(1'b1, 8'hab);
			expect_res(8'(t));
			legacy_mode = 1'b0;
			wr(1'b1, 8'ha9);
			expect_res(8'(t));
		end
		fc = 2'b00;
		fd = 2'b00;
		$display("line tests done");
		// full password, then arming blocks commands
		wr(1'b1, 8'ha5);
		for (int i = 0; i < 9; i++)
			wr(1'b0, 8'h41 + 8'(i));
		check(kb_sent, 8'h49);
		wr(1'b1, 8'ha4);
		expect_res(8'hfa);
		wr(1'b1, 8'ha6);
		wr(1'b1, 8'h20);
		rd(1'b1, s);
		check({7'h0, s[0]}, 8'h00);
		// the keyboard replays the password, which disarms
		for (int i = 0; i < 8; i++)
			kb_byte(8'h41 + 8'(i), 1'b0);
		wr(1'b1, 8'h20);
		expect_res(8'h03);
		// parity error gives ff and the flag unless the legacy type bit is set
		kb_byte(8'h5c, 1'b1);
		expect_res(8'hff);
		rd(1'b1, s);
		check({7'h0, s[7]}, 8'h01);
		legacy_mode = 1'b1;
		wr(1'b1, 8'h60);
		wr(1'b0, 8'h21);
		kb_byte(8'h5c, 1'b1);
		expect_res(8'h5c);
		rd(1'b1, s);
		check({7'h0, s[7]}, 8'h00);
		$display("password done");
		// mid-run reset clears the output port; legacy dump afterwards
		reset_dut();
		check(output_port, 8'h00);
		legacy_mode = 1'b1;
		for (int i = 1; i < 16; i++) begin
			wr(1'b1, 8'h60 + 8'(i));
			wr(1'b0, 8'hc0 + 8'(i));
		end
		wr(1'b1, 8'hac);
		expect_res(8'h10);
		for (int i = 1; i < 16; i++)
			expect_res(8'hc0 + 8'(i));
		expect_res(8'h9a);
		expect_res(8'h00);
		$display("reset and dump done");
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
